//--- include/acq_track_consts.vh
// Constants for the acquisition and tracking lock control block
// Function
// - Bit 14 enables false lock in verify
// - Enabled false lock overflow forces false-lock state unless an integration ends in that cycle
// - Disabled false lock overflow changes nothing
// - Bit 13: stepped or continuous sweep
// - Bits 12-9: verify length, 0 to 15
// - Continuous: bits 8-5 count sweep integrations
// - Stepped: bits 8-5 count compute cycles
// - Bit 4: microprocessor or state machine control
// - Microprocessor mode ignores accumulator rollover
// - Microprocessor mode halts after each period
// - Bit 3: track or acquisition parameters
// - Bit 2 drives the lock indication bit, microprocessor mode only
// - Switch to state machine with bit 2 locks
// - Bit 0 gates sweep, microprocessor mode only
// - Write to address 25 restarts detector
// - Verify uses false lock with track preloads
`ifndef ACQ_TRACK_CONSTS_VH
`define ACQ_TRACK_CONSTS_VH

// ****************************************************************
// Destination addresses
// ****************************************************************
`define ADDR_W            6
`define ADDR_ACQ_TRK_CTRL 6'h17
`define ADDR_RESTART      6'h19

// ****************************************************************
// Control word layout
// ****************************************************************
`define CTRL_W            16
`define CTRL_RESET        16'h0000
`define BIT_FL_EN         14
`define BIT_CONT_SWEEP    13
`define VERIFY_HI         12
`define VERIFY_LO         9
`define FL_SWEEP_HI       8
`define FL_SWEEP_LO       5
`define BIT_SM_CTRL       4
`define BIT_ACQ_SEL       3
`define BIT_UP_LOCK       2
`define BIT_UP_SWEEP      0
`define CNT_W             4
`define CNT_ONE           4'h1
`define STATUS_W          7

`endif

//--- design/step_counter.v
// Loadable four-bit down counter used for verify and sweep lengths
`timescale 1ns/1ns
module step_counter #(
    parameter W = 4
) (
    input  wire         ref_clk,
    input  wire         reset,
    input  wire         load,
    input  wire [W-1:0] load_val,
    input  wire         dec,
    output wire [W-1:0] count,
    output wire         is_zero
);
    reg [W-1:0] count_q;

    // Load has priority so a fresh state never sees a stale count
    always @(posedge ref_clk) begin
        if (reset) begin
            count_q <= {W{1'b0}};
        end else if (load) begin
            count_q <= load_val;
        end else if (dec && count_q != {W{1'b0}}) begin
            count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign count   = count_q;
    assign is_zero = (count_q == {W{1'b0}});
endmodule // step_counter

//--- design/acq_track_lock_control.v
// Lock detector control: control word, lock state machine, sweep gating
`timescale 1ns/1ns
`include "acq_track_consts.vh"
module acq_track_lock_control (
    input  wire                 ref_clk,
    input  wire                 reset,
    input  wire                 wr_strobe,
    input  wire [`ADDR_W-1:0]   wr_addr,
    input  wire [31:0]          wr_data,
    input  wire                 integ_done,
    input  wire                 lock_acc_ovf,
    input  wire                 false_lock_ovf,
    input  wire                 loop_compute,
    output wire [31:0]          ctrl_word,
    output wire                 lock_indication_bit,
    output wire                 acq_param_sel,
    output wire                 sweep_to_lag_en,
    output wire                 lock_acc_run,
    output wire                 false_lock_acc_en,
    output wire                 false_lock_track_preload,
    output wire                 false_lock_state,
    output wire [4:0]           sm_state
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [4:0] S_ACQ    = 5'b0_0001;
    localparam [4:0] S_VERIFY = 5'b0_0010;
    localparam [4:0] S_LOCK   = 5'b0_0100;
    localparam [4:0] S_FLOCK  = 5'b0_1000;
    localparam [4:0] S_SWITCH = 5'b1_0000;

    reg  [`CTRL_W-1:0] ctrl_q;
    reg  [4:0]         state_q;
    reg  [4:0]         state_d;
    reg                halted_q;
    reg                lock_ind_q;
    reg                acq_sel_q;
    reg                sweep_en_q;
    reg                fl_en_q;
    reg                fl_state_q;
    wire [`CTRL_W-1:0] ctrl_d;
    wire               sm_mode_d;
    wire               ctrl_wr;
    wire               restart_wr;
    wire               sm_mode;
    wire               cont_sweep;
    wire [`CNT_W-1:0]  verify_len;
    wire [`CNT_W-1:0]  sweep_len;
    wire               ver_load;
    wire               ver_dec;
    wire [`CNT_W-1:0]  ver_count;
    wire               sw_load;
    wire               sw_dec;
    wire               sw_zero;
    wire               fl_hit;
    wire               to_sm;

    // ****************************************************************
    // Control register
    // ****************************************************************
    assign ctrl_wr    = wr_strobe && (wr_addr == `ADDR_ACQ_TRK_CTRL);
    assign restart_wr = wr_strobe && (wr_addr == `ADDR_RESTART);

    // Bits 15 and 1 are stored as written; host keeps them zero
    always @(posedge ref_clk) begin
        if (reset) begin
            ctrl_q <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= wr_data[`CTRL_W-1:0];
        end
    end

    assign ctrl_word  = {16'h0000, ctrl_q};
    assign sm_mode    = ctrl_q[`BIT_SM_CTRL];
    assign cont_sweep = ctrl_q[`BIT_CONT_SWEEP];
    assign verify_len = ctrl_q[`VERIFY_HI:`VERIFY_LO];
    assign sweep_len  = ctrl_q[`FL_SWEEP_HI:`FL_SWEEP_LO];

    // Handover from microprocessor to state machine is seen on the write
    assign to_sm = ctrl_wr && !sm_mode && wr_data[`BIT_SM_CTRL];

    // ****************************************************************
    // Halt in microprocessor mode
    // ****************************************************************
    // Period end sets the halt; set wins over a same-cycle restart
    always @(posedge ref_clk) begin
        if (reset) begin
            halted_q <= 1'b0;
        end else if (!sm_mode && integ_done) begin
            halted_q <= 1'b1;
        end else if (restart_wr || sm_mode) begin
            halted_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Lock state machine
    // ****************************************************************
    // False lock only counts in verify and only when enabled
    assign fl_hit = false_lock_ovf && ctrl_q[`BIT_FL_EN]
                    && !integ_done;

    always @* begin
        state_d = state_q;
        if (to_sm) begin
            state_d = wr_data[`BIT_UP_LOCK] ? S_LOCK : S_ACQ;
        end else if (!sm_mode) begin
            state_d = S_SWITCH;
        end else begin
            case (state_q)
                S_ACQ: begin
                    if (integ_done && lock_acc_ovf) begin
                        state_d = (verify_len == {`CNT_W{1'b0}}) ?
                                  S_LOCK : S_VERIFY;
                    end
                end
                S_VERIFY: begin
                    if (fl_hit) begin
                        state_d = S_FLOCK;
                    end else if (integ_done && !lock_acc_ovf) begin
                        state_d = S_ACQ;
                    end else if (integ_done && ver_count == `CNT_ONE) begin
                        state_d = S_LOCK;
                    end
                end
                S_LOCK: begin
                    if (integ_done && !lock_acc_ovf) begin
                        state_d = S_ACQ;
                    end
                end
                S_FLOCK: begin
                    if (sw_zero) begin
                        state_d = S_ACQ;
                    end
                end
                S_SWITCH: begin
                    state_d = S_ACQ;
                end
                default: begin
                    state_d = S_ACQ;
                end
            endcase
        end
    end

    // Microprocessor mode parks the machine in S_SWITCH; it restarts in lock if bit 2 is written set, else in acquisition
    always @(posedge ref_clk) begin
        if (reset) begin
            state_q <= S_ACQ;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Verify and sweep counters
    // ****************************************************************
    assign ver_load = (state_d == S_VERIFY) && (state_q != S_VERIFY);
    assign ver_dec  = (state_q == S_VERIFY) && integ_done;

    step_counter #(.W(`CNT_W)) u_verify_cnt (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .load     (ver_load),
        .load_val (verify_len),
        .dec      (ver_dec),
        .count    (ver_count),
        .is_zero  ()
    );

    // Continuous sweep counts integrations, stepped counts computes
    assign sw_load = (state_d == S_FLOCK) && (state_q != S_FLOCK);
    assign sw_dec  = (state_q == S_FLOCK) &&
                     (cont_sweep ? integ_done : loop_compute);

    step_counter #(.W(`CNT_W)) u_sweep_cnt (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .load     (sw_load),
        .load_val (sweep_len),
        .dec      (sw_dec),
        .count    (),
        .is_zero  (sw_zero)
    );

    // ****************************************************************
    // Outputs to the loop and status path
    // ****************************************************************
    // Next-cycle view of the control word and mode for the output flops
    assign ctrl_d    = ctrl_wr ? wr_data[`CTRL_W-1:0] : ctrl_q;
    assign sm_mode_d = ctrl_d[`BIT_SM_CTRL];

    // Built from next values so outputs land in step with the state;
    // the host bits steer only while the host owns the detector
    always @(posedge ref_clk) begin
        if (reset) begin
            lock_ind_q <= 1'b0;
            acq_sel_q  <= 1'b0;
            sweep_en_q <= 1'b0;
            fl_en_q    <= 1'b0;
            fl_state_q <= 1'b0;
        end else begin
            lock_ind_q <= sm_mode_d ? (state_d == S_LOCK)
                                    : ctrl_d[`BIT_UP_LOCK];
            acq_sel_q  <= sm_mode_d ?
                          (state_d == S_ACQ || state_d == S_FLOCK)
                          : ctrl_d[`BIT_ACQ_SEL];
            sweep_en_q <= sm_mode_d ?
                          (state_d == S_ACQ || state_d == S_FLOCK)
                          : ctrl_d[`BIT_UP_SWEEP];
            fl_en_q    <= sm_mode_d && (state_d == S_VERIFY);
            fl_state_q <= (state_d == S_FLOCK);
        end
    end

    // Status and loop controls straight from flops, no decode glitches
    assign lock_indication_bit      = lock_ind_q;
    assign acq_param_sel            = acq_sel_q;
    assign sweep_to_lag_en          = sweep_en_q;
    assign lock_acc_run             = !halted_q;
    assign false_lock_acc_en        = fl_en_q;
    // Verify always runs the false-lock accumulator on track preloads
    assign false_lock_track_preload = fl_en_q;
    assign false_lock_state         = fl_state_q;
    assign sm_state                 = state_q;
endmodule // acq_track_lock_control

//--- test/host_model.sv
// Host model that writes the lock control registers
`timescale 1ns/1ns
module host_model (
    input  wire        ref_clk,
    output reg         wr_strobe,
    output reg  [5:0]  wr_addr,
    output reg  [31:0] wr_data
);
    // Idle bus at time zero
    initial begin
        wr_strobe = 1'b0;
        wr_addr   = 6'h00;
        wr_data   = 32'h0000_0000;
    end
    // ****************************************
    // One-cycle write; reserved bits 15 and 1 kept zero
    // ****************************************
    task wr(input [5:0] a, input [31:0] d);
        begin
            @(posedge ref_clk);
            wr_strobe <= 1'b1;
            wr_addr   <= a;
            wr_data   <= d & 32'hFFFF_7FFD;
            @(posedge ref_clk);
            wr_strobe <= 1'b0;
            // Released bus shows junk, not the last value
            wr_addr   <= ~a;
            wr_data   <= ~d;
        end
    endtask
endmodule // host_model

//--- test/acq_track_lock_control_properties.sv
// Concurrent checks on the lock control block ports
`timescale 1ns/1ns
module acq_track_lock_control_properties (
    input wire        ref_clk,
    input wire        reset,
    input wire        wr_strobe,
    input wire [5:0]  wr_addr,
    input wire [31:0] wr_data,
    input wire        integ_done,
    input wire        false_lock_ovf,
    input wire [31:0] ctrl_word,
    input wire        lock_indication_bit,
    input wire        acq_param_sel,
    input wire        sweep_to_lag_en,
    input wire        lock_acc_run,
    input wire        false_lock_acc_en,
    input wire        false_lock_track_preload,
    input wire [4:0]  sm_state
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    sequence s_ctrl_wr;
        wr_strobe && wr_addr == 6'h17;
    endsequence
    sequence s_to_sm;
        s_ctrl_wr ##0 (!ctrl_word[4] && wr_data[4] && wr_data[2]);
    endsequence
    sequence s_fl_hit;
        ctrl_word[4] && sm_state == 5'h02 && false_lock_ovf
            && !integ_done && !wr_strobe;
    endsequence
    property p_ctrl;
        s_ctrl_wr |=> ctrl_word == (32'h0000_FFFF & $past(wr_data));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl word");
    property p_up_out;
        !ctrl_word[4] |-> lock_indication_bit == ctrl_word[2]
            && acq_param_sel == ctrl_word[3]
            && sweep_to_lag_en == ctrl_word[0];
    endproperty
    a_up_out: assert property (p_up_out) else $error("up outs");
    property p_sm_lock;
        ctrl_word[4] |-> lock_indication_bit == (sm_state == 5'h04);
    endproperty
    a_sm_lock: assert property (p_sm_lock) else $error("sm lock");
    property p_halt;
        !ctrl_word[4] && integ_done |=> !lock_acc_run;
    endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_restart;
        wr_strobe && wr_addr == 6'h19 && !integ_done |=> lock_acc_run;
    endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_flock;
        s_fl_hit ##0 ctrl_word[14] |=> sm_state == 5'h08;
    endproperty
    a_flock: assert property (p_flock) else $error("flock");
    property p_nofl;
        s_fl_hit ##0 !ctrl_word[14] |=> sm_state == 5'h02;
    endproperty
    a_nofl: assert property (p_nofl) else $error("no flock");
    property p_fl_en;
        false_lock_acc_en == (ctrl_word[4] && sm_state == 5'h02)
            && false_lock_track_preload == false_lock_acc_en;
    endproperty
    a_fl_en: assert property (p_fl_en) else $error("fl enable");
    property p_switch;
        s_to_sm |=> sm_state == 5'h04 && lock_indication_bit;
    endproperty
    a_switch: assert property (p_switch) else $error("switch");
endmodule // acq_track_lock_control_properties
bind acq_track_lock_control acq_track_lock_control_properties u_props (
    .ref_clk(ref_clk), .reset(reset), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .integ_done(integ_done),
    .false_lock_ovf(false_lock_ovf), .ctrl_word(ctrl_word),
    .lock_indication_bit(lock_indication_bit),
    .acq_param_sel(acq_param_sel), .sweep_to_lag_en(sweep_to_lag_en),
    .lock_acc_run(lock_acc_run), .false_lock_acc_en(false_lock_acc_en),
    .false_lock_track_preload(false_lock_track_preload),
    .sm_state(sm_state));

//--- test/acq_track_lock_control_bench.sv
// Self-checking bench for the lock control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares = compares + 1; \
    if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("Error %s exp %h got %h", n, e, g); end end
module acq_track_lock_control_bench;
    reg         ref_clk, reset, integ_done, lock_acc_ovf;
    reg         false_lock_ovf, loop_compute;
    wire        wr_strobe, lock_bit, acq_sel, sweep_en;
    wire        acc_run, fl_en, fl_pre, fl_st;
    wire [5:0]  wr_addr;
    wire [31:0] wr_data, ctrl_word;
    wire [4:0]  sm_state;
    integer     mismatches, compares;
    host_model host (.ref_clk(ref_clk), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data));
    acq_track_lock_control dut (.ref_clk(ref_clk), .reset(reset),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
        .integ_done(integ_done), .lock_acc_ovf(lock_acc_ovf),
        .false_lock_ovf(false_lock_ovf), .loop_compute(loop_compute),
        .ctrl_word(ctrl_word), .lock_indication_bit(lock_bit),
        .acq_param_sel(acq_sel), .sweep_to_lag_en(sweep_en),
        .lock_acc_run(acc_run), .false_lock_acc_en(fl_en),
        .false_lock_track_preload(fl_pre), .false_lock_state(fl_st),
        .sm_state(sm_state));
    // ****************************************
    // Helpers
    // ****************************************
    task wr(input [5:0] a, input [31:0] d);
        begin
            host.wr(a, d);
            #1;
        end
    endtask
    // One-cycle pulse on the detector inputs
    task pulse(input i, input o, input f, input c);
        begin
            @(posedge ref_clk);
            {integ_done, lock_acc_ovf, false_lock_ovf, loop_compute} <=
                {i, o, f, c};
            @(posedge ref_clk);
            {integ_done, lock_acc_ovf, false_lock_ovf, loop_compute} <= 4'h0;
            #1;
        end
    endtask
    task finish_test;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Host-driven outputs, unmapped write ignored
    task t_up;
        begin
            `CHK("ctrl", 32'h0000_0000, ctrl_word)
            `CHK("lock", 1'b0, lock_bit)
            wr(6'h17, 32'h0000_800F);
            `CHK("ctrl", 32'h0000_000D, ctrl_word)
            `CHK("lock", 1'b1, lock_bit)
            `CHK("acq", 1'b1, acq_sel)
            `CHK("sweep", 1'b1, sweep_en)
            wr(6'h18, 32'h0000_0000);
            `CHK("ctrl", 32'h0000_000D, ctrl_word)
            wr(6'h17, 32'h0000_0000);
            `CHK("acq", 1'b0, acq_sel)
            `CHK("sweep", 1'b0, sweep_en)
            $display("t_up done");
        end
    endtask
    // Halt at period end, overflow ignored, restart
    task t_halt;
        begin
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            `CHK("run", 1'b0, acc_run)
            `CHK("state", 5'h10, sm_state)
            repeat (3) @(posedge ref_clk);
            #1;
            `CHK("run", 1'b0, acc_run)
            wr(6'h19, 32'h0000_0000);
            `CHK("run", 1'b1, acc_run)
            $display("t_halt done");
        end
    endtask
    // Switch to state machine, verify, false lock, stepped sweep
    task t_sm;
        begin
            wr(6'h17, 32'h0000_4434);
            `CHK("state", 5'h04, sm_state)
            pulse(1'b1, 1'b0, 1'b0, 1'b0);
            `CHK("lock", 1'b0, lock_bit)
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            `CHK("fl_pre", 1'b1, fl_pre)
            `CHK("fl_en", 1'b1, fl_en)
            pulse(1'b0, 1'b0, 1'b1, 1'b0);
            `CHK("fl_st", 1'b1, fl_st)
            pulse(1'b0, 1'b0, 1'b0, 1'b1);
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("state", 5'h01, sm_state)
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            `CHK("state", 5'h02, sm_state)
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            `CHK("state", 5'h04, sm_state)
            wr(6'h17, 32'h0000_0410);
            pulse(1'b1, 1'b0, 1'b0, 1'b0);
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            pulse(1'b0, 1'b0, 1'b1, 1'b0);
            `CHK("state", 5'h02, sm_state)
            $display("t_sm done");
        end
    endtask
    // Continuous sweep counts integrations only; zero verify locks at once
    task t_cont;
        begin
            wr(6'h17, 32'h0000_6050);
            pulse(1'b0, 1'b0, 1'b1, 1'b0);
            `CHK("fl_st", 1'b1, fl_st)
            pulse(1'b0, 1'b0, 1'b0, 1'b1);
            pulse(1'b1, 1'b0, 1'b0, 1'b0);
            pulse(1'b1, 1'b0, 1'b0, 1'b0);
            `CHK("state", 5'h08, sm_state)
            @(posedge ref_clk);
            #1;
            `CHK("state", 5'h01, sm_state)
            pulse(1'b1, 1'b1, 1'b0, 1'b0);
            `CHK("state", 5'h04, sm_state)
            `CHK("lock", 1'b1, lock_bit)
            `CHK("fl_en", 1'b0, fl_en)
            $display("t_cont done");
        end
    endtask
    // Clock, reset, sequence and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        mismatches = mismatches + 1;
        finish_test;
    end
    initial begin
        {reset, integ_done, lock_acc_ovf} = 3'b100;
        {false_lock_ovf, loop_compute} = 2'b00;
        mismatches = 0;
        compares = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        t_up;
        t_halt;
        t_sm;
        t_cont;
        finish_test;
    end
endmodule // acq_track_lock_control_bench
